// ### logic/cps_pkg.sv
// What this block does
// - start only after supply stable 5 ms
// - power-on reset restores control register defaults
// - refuse host access until 5 ms later
// - input loss with good battery: battery mode
// - input loss, weak battery: off, later re-reset
// - 50 ms deglitch before enabling bias regulators
// - bias ramped: power good, adapter flag set
// - sample strap once after power-on reset
// - 100 ms sink pulse, input inside window
// - failed qualification retries every 2 s
// - detect cell count during qualification
// - set input current limit during qualification
// - one unloaded input conversion, result stored
// - hold converter while input short flagged
// - converter starts 226 ms after enable threshold
// - battery only: wake, close battery switch
// - battery start-up defaults to low power
// - low-power bias current limit reduced
// - battery only keeps adapter comparator active
// - host picks performance mode, buffer enable
// - cell detect on pin or bias rise, except in battery low power
// - switching frequency bit from strap decode
package cps_pkg;
    localparam int CLK_KHZ        = 125000;
    localparam int CYC_PER_MS     = CLK_KHZ;
    localparam int TMR_W          = 12;
    localparam int T_STABLE_MS    = 5;
    localparam int T_ACCESS_MS    = 5;
    localparam int T_DEGLITCH_MS  = 50;
    localparam int T_QUAL_MS      = 100;
    localparam int T_RETRY_S      = 2;
    localparam int T_CONV_MS      = 226;
    localparam int T_RETRY_MS     = T_RETRY_S * 1000;

    localparam int ADDR_W         = 12;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CONFIG = 12'h008;
    localparam logic [11:0] ADDR_VBUS   = 12'h00C;

    // control register fields
    localparam int CTRL_LP_BIT    = 0;
    localparam int CTRL_IBUF_BIT  = 1;
    localparam int CTRL_FREQ_BIT  = 2;
    localparam int CTRL_BIASLP_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h1;
    // strap fields
    localparam int STRAP_FREQ_BIT = 0;
    localparam int STRAP_COMP_BIT = 1;
    localparam int STRAP_TOPO_BIT = 2;
    // status and config field positions
    localparam int ST_ADAPTER_BIT = 0;
    localparam int ST_PGOOD_BIT   = 1;
    localparam int ST_QFAIL_BIT   = 2;
    localparam int ST_ACCESS_BIT  = 3;
    localparam int ST_STATE_LSB   = 8;
    localparam int CF_STRAP_LSB   = 8;
    localparam int CF_CELL_LSB    = 12;
    localparam logic [2:0] CELL_MIN = 3'h2;
    localparam logic [2:0] CELL_MAX = 3'h5;

    typedef struct packed {
        logic        vbus_ok;
        logic        vbat_ok;
        logic        vbus_conven;
        logic        vbus_acov;
        logic        bias_good;
        logic        input_path_short_flag;
        logic        cell_config_pin;
        logic        adc_done;
        logic [2:0]  cell_code;
        logic [2:0]  strap_code;
        logic [5:0]  input_limit_pin;
        logic [15:0] adc_data;
    } cps_pins_t;

    typedef struct packed {
        logic power_good_out;
        logic bias_en;
        logic bias_ilim_low;
        logic sink_pulse_en;
        logic battery_switch;
        logic conv_en;
        logic adc_start;
        logic adapter_comp_en;
        logic batt_current_buffer_en;
    } cps_pwr_t;
endpackage

// ### logic/cps_timer.sv
`timescale 1ns/100ps
module cps_timer #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         tick,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              done
);
    if (W < 2) begin : g_bad_w
        $error("cps_timer: W too small");
    end

    logic [W-1:0] cnt_q;
    logic         run_q;
    logic         done_q;

    // one extra tick so a start mid-period never falls short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_q  <= len;
                run_q  <= 1'b1;
                done_q <= 1'b0;
            end else if (run_q && tick) begin
                if (cnt_q == '0) begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    assign done = done_q;
endmodule

// ### logic/cps_seq.sv
`timescale 1ns/100ps
module cps_seq #(
    parameter int TICK_CYCLES = cps_pkg::CYC_PER_MS
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       ce,
    input  wire logic [cps_pkg::ADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire cps_pkg::cps_pins_t         pins,
    output cps_pkg::cps_pwr_t               pwr
);
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("cps_seq: TICK_CYCLES too small");
    end

    typedef enum logic [3:0] {
        S_OFF, S_START, S_POR, S_BATT, S_DEGLITCH, S_BIAS,
        S_QUAL, S_RETRY, S_ADC, S_WAITCONV, S_RUN
    } cps_state_t;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and millisecond timebase
    cps_pkg::cps_pins_t meta_q;
    cps_pkg::cps_pins_t s_q;
    logic               cfg_pin_prev_q;
    logic               bias_good_prev_q;
    logic [31:0]        tick_cnt_q;
    logic               tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q           <= '0;
            s_q              <= '0;
            cfg_pin_prev_q   <= 1'b0;
            bias_good_prev_q <= 1'b0;
        end else if (ce) begin
            meta_q           <= pins;
            s_q              <= meta_q;
            cfg_pin_prev_q   <= s_q.cell_config_pin;
            bias_good_prev_q <= s_q.bias_good;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else if (ce) begin
            tick_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
            if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
                tick_cnt_q <= 32'h0000_0000;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    cps_state_t                 state_q;
    cps_state_t                 state_d;
    logic                       seq_start;
    logic [cps_pkg::TMR_W-1:0]  seq_len;
    logic                       seq_done;
    logic                       acc_done;
    logic                       conv_done;
    logic [3:0]                 ctrl_q;
    logic                       access_ok_q;
    logic                       qual_fail_q;

    wire supply_ok    = s_q.vbus_ok | s_q.vbat_ok;
    wire adapter_path = (state_q == S_DEGLITCH) | (state_q == S_BIAS) | (state_q == S_QUAL) |
                        (state_q == S_RETRY) | (state_q == S_ADC) | (state_q == S_WAITCONV) |
                        (state_q == S_RUN);
    wire powered      = (state_q == S_QUAL) | (state_q == S_RETRY) | (state_q == S_ADC) |
                        (state_q == S_WAITCONV) | (state_q == S_RUN);
    wire low_power    = ctrl_q[cps_pkg::CTRL_LP_BIT];
    wire por          = (state_q == S_POR);
    wire qual_end     = (state_q == S_QUAL) & seq_done;
    wire qual_bad     = ~s_q.vbus_conven | s_q.vbus_acov;
    wire enter_batt   = (state_d == S_BATT) & (state_q != S_BATT);
    wire batt_lp      = (state_q == S_BATT) & low_power;
    wire cell_rise    = (s_q.cell_config_pin & ~cfg_pin_prev_q) | (s_q.bias_good & ~bias_good_prev_q);
    wire cell_detect  = qual_end | (cell_rise & ~batt_lp);
    wire conv_hold    = ~s_q.vbus_conven | ~adapter_path;

    always_comb begin
        state_d   = state_q;
        seq_start = 1'b0;
        seq_len   = '0;
        case (state_q)
            S_OFF: begin
                if (supply_ok) begin
                    state_d   = S_START;
                    seq_start = 1'b1;
                    seq_len   = cps_pkg::TMR_W'(cps_pkg::T_STABLE_MS);
                end
            end
            S_START: begin
                if (!supply_ok) begin
                    state_d = S_OFF;
                end else if (seq_done) begin
                    state_d = S_POR;
                end
            end
            S_POR, S_BATT: begin
                if (s_q.vbus_ok) begin
                    state_d   = S_DEGLITCH;
                    seq_start = 1'b1;
                    seq_len   = cps_pkg::TMR_W'(cps_pkg::T_DEGLITCH_MS);
                end else if (!s_q.vbat_ok) begin
                    state_d = S_OFF;
                end else begin
                    state_d = S_BATT;
                end
            end
            S_DEGLITCH: begin
                if (seq_done) begin
                    state_d = S_BIAS;
                end
            end
            S_BIAS: begin
                if (s_q.bias_good) begin
                    state_d   = S_QUAL;
                    seq_start = 1'b1;
                    seq_len   = cps_pkg::TMR_W'(cps_pkg::T_QUAL_MS);
                end
            end
            S_QUAL: begin
                if (seq_done && (qual_fail_q || qual_bad)) begin
                    state_d   = S_RETRY;
                    seq_start = 1'b1;
                    seq_len   = cps_pkg::TMR_W'(cps_pkg::T_RETRY_MS);
                end else if (seq_done) begin
                    state_d = S_ADC;
                end
            end
            S_RETRY: begin
                if (seq_done) begin
                    state_d   = S_QUAL;
                    seq_start = 1'b1;
                    seq_len   = cps_pkg::TMR_W'(cps_pkg::T_QUAL_MS);
                end
            end
            S_ADC: begin
                if (s_q.adc_done) begin
                    state_d = S_WAITCONV;
                end
            end
            S_WAITCONV: begin
                if (conv_done && !s_q.input_path_short_flag) begin
                    state_d = S_RUN;
                end
            end
            S_RUN: state_d = S_RUN;
            default: begin
                state_d = S_OFF;
            end
        endcase
        // adapter removal: battery mode if the cell holds up, else dead
        if (adapter_path && !s_q.vbus_ok) begin
            state_d   = s_q.vbat_ok ? S_BATT : S_OFF;
            seq_start = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_OFF;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    cps_timer #(.W(cps_pkg::TMR_W)) u_seq_tmr (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .tick  (tick_q),
        .start (seq_start),
        .len   (seq_len),
        .done  (seq_done)
    );

    cps_timer #(.W(cps_pkg::TMR_W)) u_acc_tmr (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .tick  (tick_q),
        .start (por),
        .len   (cps_pkg::TMR_W'(cps_pkg::T_ACCESS_MS)),
        .done  (acc_done)
    );

    // restarted while below the enable threshold, so it measures from the crossing
    cps_timer #(.W(cps_pkg::TMR_W)) u_conv_tmr (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .tick  (tick_q),
        .start (conv_hold),
        .len   (cps_pkg::TMR_W'(cps_pkg::T_CONV_MS)),
        .done  (conv_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // captured configuration
    logic [2:0]  strap_q;
    logic [2:0]  cell_count_q;
    logic [5:0]  input_current_limit_q;
    logic [15:0] input_voltage_result_q;

    // widened: a high code must saturate, not wrap
    wire [2:0] cell_dec = ({1'b0, s_q.cell_code} + {1'b0, cps_pkg::CELL_MIN} > {1'b0, cps_pkg::CELL_MAX}) ?
                          cps_pkg::CELL_MAX : 3'(s_q.cell_code + cps_pkg::CELL_MIN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_q                <= 3'h0;
            cell_count_q           <= cps_pkg::CELL_MIN;
            input_current_limit_q  <= 6'h00;
            input_voltage_result_q <= 16'h0000;
            qual_fail_q            <= 1'b0;
            access_ok_q            <= 1'b0;
        end else if (ce) begin
            if (por) begin
                strap_q <= s_q.strap_code;
            end
            if (cell_detect) begin
                cell_count_q <= cell_dec;
            end
            if (qual_end) begin
                input_current_limit_q <= s_q.input_limit_pin;
            end
            if (state_q == S_ADC && s_q.adc_done) begin
                input_voltage_result_q <= s_q.adc_data;
            end
            if (seq_start && state_d == S_QUAL) begin
                qual_fail_q <= 1'b0;
            end else if (state_q == S_QUAL && qual_bad) begin
                qual_fail_q <= 1'b1;
            end
            access_ok_q <= acc_done & ~por & (state_d > S_POR);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;

    wire        acc     = psel & penable & ~pready_q;
    wire        hit_c   = (paddr == cps_pkg::ADDR_CTRL);
    wire        hit_s   = (paddr == cps_pkg::ADDR_STATUS);
    wire        hit_f   = (paddr == cps_pkg::ADDR_CONFIG);
    wire        hit_v   = (paddr == cps_pkg::ADDR_VBUS);
    wire        mapped  = hit_c | hit_s | hit_f | hit_v;
    wire        bad     = ~access_ok_q | ~mapped | (pwrite & ~hit_c);
    wire        wr_ctrl = acc & pwrite & ~bad & pstrb[0];
    wire [31:0] st_word = {20'h00000, 4'(state_q), 4'h0, access_ok_q, qual_fail_q,
                           pwr.power_good_out, powered};
    wire [31:0] cf_word = {17'h00000, cell_count_q, 1'b0, strap_q, 2'h0, input_current_limit_q};
    wire [31:0] rd_word = hit_c ? {28'h0000000, ctrl_q} :
                          hit_s ? st_word :
                          hit_f ? cf_word :
                          hit_v ? {16'h0000, input_voltage_result_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= acc;
            pslverr_q <= acc & bad;
            prdata_q  <= (acc && !pwrite && !bad) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= cps_pkg::CTRL_RST;
        end else if (ce) begin
            if (por) begin
                ctrl_q                         <= cps_pkg::CTRL_RST;
                ctrl_q[cps_pkg::CTRL_FREQ_BIT] <= s_q.strap_code[cps_pkg::STRAP_FREQ_BIT];
            end else if (enter_batt) begin
                ctrl_q[cps_pkg::CTRL_LP_BIT] <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q <= pwdata[3:0];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // power outputs
    cps_pkg::cps_pwr_t pwr_q;
    cps_pkg::cps_pwr_t pwr_d;
    wire bias_lp_en = ctrl_q[cps_pkg::CTRL_BIASLP_BIT];

    always_comb begin
        pwr_d                        = '0;
        pwr_d.bias_en                = adapter_path & (state_q != S_DEGLITCH) |
                                       (state_q == S_BATT) & (~low_power | bias_lp_en);
        pwr_d.bias_ilim_low          = batt_lp & bias_lp_en;
        pwr_d.power_good_out         = powered;
        pwr_d.sink_pulse_en          = (state_d == S_QUAL);
        pwr_d.battery_switch         = (state_d == S_BATT);
        pwr_d.conv_en                = (state_d == S_RUN);
        pwr_d.adc_start              = (state_q == S_QUAL) & (state_d == S_ADC);
        pwr_d.adapter_comp_en        = (state_d == S_BATT);
        pwr_d.batt_current_buffer_en = ctrl_q[cps_pkg::CTRL_IBUF_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= '0;
        end else if (ce) begin
            pwr_q <= pwr_d;
        end
    end

    assign pwr = pwr_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_qual_pass;
        (state_q == S_QUAL) ##1 (state_q == S_ADC);
    endsequence

    a_por_defaults: assert property ((por && ce) |=> ctrl_q[cps_pkg::CTRL_LP_BIT])
        else $error("low power bit not defaulted at reset");
    a_early_refused: assert property ((acc && ce && !access_ok_q) |=> pslverr_q && pready_q)
        else $error("register access taken before delay");
    a_batt_lowpwr: assert property ((ce && enter_batt) |=> (state_q == S_BATT) && low_power)
        else $error("battery mode entered without low power");
    a_off_no_bus: assert property ((state_q == S_OFF) |-> !access_ok_q)
        else $error("bus open while device off");
    a_deglitch_bias: assert property ((state_q == S_DEGLITCH) && ce |=> !pwr_q.bias_en)
        else $error("bias enabled during deglitch");
    a_pgood_source: assert property ($rose(pwr_q.power_good_out) |-> $past(s_q.bias_good, 2))
        else $error("power good before bias ramp");
    a_qual_sink: assert property ((state_q == S_QUAL) |-> pwr_q.sink_pulse_en)
        else $error("sink pulse missing in qualification");
    a_retry_off: assert property ((state_q == S_RETRY) |-> !pwr_q.conv_en)
        else $error("converter on during retry");
    a_adc_once: assert property (s_qual_pass |-> pwr_q.adc_start ##1 !pwr_q.adc_start)
        else $error("conversion not a single pulse");
    a_short_hold: assert property ((state_q == S_WAITCONV && s_q.input_path_short_flag && ce)
                                   |=> !pwr_q.conv_en)
        else $error("converter started during input short");
    a_lp_ilim: assert property (pwr_q.bias_ilim_low |-> $past(low_power))
        else $error("reduced limit outside low power");
endmodule

// ### tb/cps_host.sv
`timescale 1ns/100ps
module cps_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////
    // request held until pready seen high at an edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
    localparam int MS = 10;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               ce = 1'b1;
    logic               psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    cps_pkg::cps_pins_t pins;
    cps_pkg::cps_pwr_t  pwr;
    int                 seed = 32'h78BDC8DB;
    int                 bad_count = 0;
    int                 checked = 0;
    logic [2:0]         strap;
    logic [2:0]         cc;
    logic [3:0]         w;
    logic [15:0]        adc;

    always #4 pclk = ~pclk;

    // short tick so the 2 s retry fits the run
    cps_seq #(.TICK_CYCLES(MS)) uut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .pwr(pwr));
    // host drives one transfer per call; the test also reads early, before the access delay, to see it refused
    cps_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic chb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [2:0] cells(input logic [2:0] c);
        return (c > 3'h3) ? 3'h5 : c + 3'h2;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic rdreg(input logic [11:0] a);
        host.xfer(a, 1'b0, 32'h0, rd, err);
    endtask
    task automatic wrreg(input logic [11:0] a, input logic [31:0] d);
        host.xfer(a, 1'b1, d, rd, err);
    endtask
    // access refused early, then defaults with strap-derived frequency bit
    task automatic por_check;
        strap = 3'($random(seed));
        pins.strap_code <= strap;
        pins.vbus_ok <= 1'b1;
        cyc(2 * MS);
        rdreg(cps_pkg::ADDR_CTRL);
        chb(err, 1'b1);
        cyc(6 * MS);
        rdreg(cps_pkg::ADDR_CTRL);
        chb(err, 1'b1);
        cyc(5 * MS);
        rdreg(cps_pkg::ADDR_CTRL);
        chb(err, 1'b0);
        chk(rd, {29'h0, strap[0], 2'h1});
        $display("test power-on reset done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        pins = '0;
        pins.input_limit_pin = 6'($random(seed));
        pins.cell_code = 3'($random(seed));
        pins.input_path_short_flag = 1'b1;
        cyc(12);
        presetn <= 1'b1;
        por_check;
        pins.strap_code <= ~strap;
        cyc(33 * MS);
        chb(pwr.bias_en, 1'b0);
        for (int n = 0; n < 15 * MS && !pwr.bias_en; n++) @(posedge pclk);
        chb(pwr.bias_en, 1'b1);
        pins.bias_good <= 1'b1;
        cyc(8);
        chb(pwr.power_good_out, 1'b1);
        chb(pwr.sink_pulse_en, 1'b1);
        rdreg(cps_pkg::ADDR_STATUS);
        chk(rd & 32'h3, 32'h3);
        // input below enable threshold: qualification must fail
        for (int n = 0; n < 110 * MS && pwr.sink_pulse_en; n++) @(posedge pclk);
        pins.vbus_conven <= 1'b1;
        rdreg(cps_pkg::ADDR_STATUS);
        chk(rd & 32'h4, 32'h4);
        for (int n = 0; n < 1900 * MS; n++) begin
            @(posedge pclk);
            if (pwr.sink_pulse_en !== 1'b0 || pwr.conv_en !== 1'b0) chb(1'b1, 1'b0);
        end
        for (int n = 0; n < 200 * MS && !pwr.sink_pulse_en; n++) @(posedge pclk);
        chb(pwr.sink_pulse_en, 1'b1);
        cyc(95 * MS);
        chb(pwr.sink_pulse_en, 1'b1);
        for (int n = 0; n < 20 * MS && !pwr.adc_start; n++) @(posedge pclk);
        chb(pwr.adc_start, 1'b1);
        adc = 16'($random(seed));
        pins.adc_data <= adc;
        pins.adc_done <= 1'b1;
        pins.vbus_conven <= 1'b0;
        cyc(10);
        pins.vbus_conven <= 1'b1;
        rdreg(cps_pkg::ADDR_VBUS);
        chk(rd, {16'h0, adc});
        rdreg(cps_pkg::ADDR_CONFIG);
        chk(rd & 32'h773F, {17'h0, cells(pins.cell_code), 1'b0, strap, 2'h0, pins.input_limit_pin});
        cyc(215 * MS);
        chb(pwr.conv_en, 1'b0);
        cyc(20 * MS);
        chb(pwr.conv_en, 1'b0);
        // enable low: short clears but nothing may move
        ce <= 1'b0;
        pins.input_path_short_flag <= 1'b0;
        cyc(8);
        chb(pwr.conv_en, 1'b0);
        ce <= 1'b1;
        cyc(8);
        chb(pwr.conv_en, 1'b1);
        $display("test adapter path done");
        w = 4'($random(seed));
        wrreg(cps_pkg::ADDR_CTRL, {28'h0, w});
        rdreg(cps_pkg::ADDR_CTRL);
        chk(rd, {28'h0, w});
        chb(pwr.batt_current_buffer_en, w[1]);
        wrreg(cps_pkg::ADDR_STATUS, 32'hF);
        chb(err, 1'b1);
        rdreg(12'h010);
        chb(err, 1'b1);
        pins.vbat_ok <= 1'b1;
        pins.vbus_ok <= 1'b0;
        cyc(8);
        chb(pwr.battery_switch, 1'b1);
        chb(pwr.adapter_comp_en, 1'b1);
        rdreg(cps_pkg::ADDR_CTRL);
        chk(rd & 32'h1, 32'h1);
        wrreg(cps_pkg::ADDR_CTRL, 32'h9);
        cyc(2);
        chk({30'h0, pwr.bias_en, pwr.bias_ilim_low}, 32'h3);
        // pin rise in low power must not reload the cell count
        cc = pins.cell_code;
        pins.cell_code <= (cc > 3'h2) ? 3'h0 : 3'h3;
        pins.cell_config_pin <= 1'b1;
        cyc(6);
        rdreg(cps_pkg::ADDR_CONFIG);
        chk(rd & 32'h7000, {17'h0, cells(cc), 12'h0});
        wrreg(cps_pkg::ADDR_CTRL, 32'h0);
        cyc(2);
        chk({30'h0, pwr.bias_en, pwr.bias_ilim_low}, 32'h2);
        pins.cell_config_pin <= 1'b0;
        cyc(4);
        pins.cell_config_pin <= 1'b1;
        cyc(6);
        rdreg(cps_pkg::ADDR_CONFIG);
        chk(rd & 32'h7000, {17'h0, cells(pins.cell_code), 12'h0});
        wrreg(cps_pkg::ADDR_CTRL, 32'h1);
        cyc(2);
        chb(pwr.bias_en, 1'b0);
        $display("test battery mode done");
        pins.vbus_ok <= 1'b1;
        cyc(4);
        pins.vbat_ok <= 1'b0;
        pins.vbus_ok <= 1'b0;
        pins.adc_done <= 1'b0;
        cyc(8);
        chk({23'h0, pwr}, 32'h0);
        por_check;
        finish_test;
    end

    // whole sequence is about 25000 cycles
    initial begin
        cyc(40000);
        bad_count++;
        finish_test;
    end
endmodule
